/* File: cmp_ctrl.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - synced latched output and raw async output
// - result polled, interrupt source, or pin
// - disabled comparator forces pin outputs low
// - pin output open drain or push pull
// - comparator output usable as reset request
// - input select register drives analogue mux
// - response mode register drives analogue core
// - low four control bits set hysteresis
// - positive and negative hysteresis independent
// - separate rising and falling interrupt causes
// - falling transition sets falling flag
// - rising transition sets rising flag
// - flags stay set until software writes zero
// - rising irq is enable and flag
// - falling irq is enable and flag
// - state bit reads current comparator output
// - enable bit turns comparator on or off
// - control register 0x9b resets to zero
// - two bit response mode resets to 2
// - irq enables at mode bits 5, 4
// - four bit selectors, msb means none
module cmp_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analogue core
  input wire logic cmp_result_async,
  output logic cmp_enable,
  output logic [1:0] pos_hyst_sel,
  output logic [1:0] neg_hyst_sel,
  output logic [1:0] response_mode_sel,
  output logic [3:0] pos_input_sel,
  output logic [3:0] neg_input_sel,
  // port crossbar
  output logic sync_cmp_out,
  output logic sync_cmp_oe_n,
  output logic raw_cmp_gate,
  output logic raw_cmp_oe_n,
  // interrupt controller and reset logic
  output logic rise_irq,
  output logic fall_irq,
  output logic cmp_reset_req
);
  import cmp_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic enable; // comparator enable
    logic rise_flag; // sticky rising flag
    logic fall_flag; // sticky falling flag
    logic [1:0] pos_hyst; // positive hysteresis code
    logic [1:0] neg_hyst; // negative hysteresis code
    logic rise_en; // rising irq enable
    logic fall_en; // falling irq enable
    logic [1:0] mode; // response mode
    logic [7:0] mux; // input selectors
    logic open_drain; // pin driver style
    logic rst_src; // comparator selected as reset source
    logic prev; // last synced result
    logic awready; // bus outputs
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sync_out; // latched output to pin
    logic sync_oe_n;
    logic raw_gate; // gate for raw path in crossbar
    logic raw_oe_n;
    logic rise_irq; // masked requests
    logic fall_irq;
    logic reset_req;
  } ctrl_state_t;
  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic cmp_sync_val; // synchronised comparator result
  logic rise_evt; // rising transition this cycle
  logic fall_evt; // falling transition this cycle
  logic wr_fire; // write completes this cycle
  logic wr_ctrl; // write hits control with low lane

  // ***************************************************************
  // synchroniser
  // ***************************************************************
  // raw result is asynchronous, so nothing reads it before two flops
  cmp_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(cmp_result_async),
    .sync_out(cmp_sync_val)
  );

  // edge events from the synchronised value only
  assign rise_evt = cmp_sync_val & ~state_reg.prev;
  assign fall_evt = ~cmp_sync_val & state_reg.prev;

  assign wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
  assign wr_ctrl = wr_fire && state_reg.aw_addr == CTRL_ADDR && state_reg.w_strb[0];

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.prev = cmp_sync_val;
    // write address and data may come in either order
    state_next.awready = ~state_reg.aw_held & ~s_axi_awready;
    state_next.wready = ~state_reg.w_held & ~s_axi_wready;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
      state_next.wready = 1'b0;
    end
    // apply write once both halves are held
    if (wr_fire) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (state_reg.w_strb[0]) begin
        case (state_reg.aw_addr)
          CTRL_ADDR: begin
            state_next.enable = state_reg.w_data[EN_BIT];
            state_next.rise_flag = state_reg.w_data[RISE_BIT];
            state_next.fall_flag = state_reg.w_data[FALL_BIT];
            state_next.pos_hyst = state_reg.w_data[POS_HYST_LSB +: 2];
            state_next.neg_hyst = state_reg.w_data[NEG_HYST_LSB +: 2];
          end
          MODE_ADDR: begin
            state_next.rise_en = state_reg.w_data[RISE_BIT];
            state_next.fall_en = state_reg.w_data[FALL_BIT];
            state_next.mode = state_reg.w_data[MODE_LSB +: 2];
          end
          MUX_ADDR: begin
            state_next.mux = state_reg.w_data[7:0];
          end
          PIN_ADDR: begin
            state_next.open_drain = state_reg.w_data[OD_BIT];
            state_next.rst_src = state_reg.w_data[RST_SRC_BIT];
          end
          default: begin
            state_next.bresp = RESP_SLVERR; // unmapped
          end
        endcase
      end else if (state_reg.aw_addr != CTRL_ADDR && state_reg.aw_addr != MODE_ADDR
                   && state_reg.aw_addr != MUX_ADDR && state_reg.aw_addr != PIN_ADDR) begin
        state_next.bresp = RESP_SLVERR; // unmapped, no lane
      end
    end
    // hardware set wins over a same cycle software clear
    if (rise_evt) begin
      state_next.rise_flag = 1'b1;
    end
    if (fall_evt) begin
      state_next.fall_flag = 1'b1;
    end
    // response handshake, next write only after it
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
    end
    // read channel: accept one, answer next cycle
    state_next.arready = ~state_reg.rvalid & ~s_axi_arready;
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        CTRL_ADDR: begin
          state_next.rdata[EN_BIT] = state_reg.enable;
          state_next.rdata[STATE_BIT] = cmp_sync_val;
          state_next.rdata[RISE_BIT] = state_reg.rise_flag;
          state_next.rdata[FALL_BIT] = state_reg.fall_flag;
          state_next.rdata[POS_HYST_LSB +: 2] = state_reg.pos_hyst;
          state_next.rdata[NEG_HYST_LSB +: 2] = state_reg.neg_hyst;
        end
        MODE_ADDR: begin
          state_next.rdata[RISE_BIT] = state_reg.rise_en;
          state_next.rdata[FALL_BIT] = state_reg.fall_en;
          state_next.rdata[MODE_LSB +: 2] = state_reg.mode;
        end
        MUX_ADDR: begin
          state_next.rdata[7:0] = state_reg.mux;
        end
        PIN_ADDR: begin
          state_next.rdata[OD_BIT] = state_reg.open_drain;
          state_next.rdata[RST_SRC_BIT] = state_reg.rst_src;
        end
        default: begin
          state_next.rresp = RESP_SLVERR; // unmapped reads zero
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // pin outputs; forced low while disabled
    state_next.sync_out = state_reg.enable & cmp_sync_val;
    // open drain: release (oe_n high) when output is one
    state_next.sync_oe_n = state_reg.open_drain & state_reg.enable & cmp_sync_val;
    state_next.raw_gate = state_reg.enable;
    state_next.raw_oe_n = state_reg.open_drain & state_reg.enable;
    // masked interrupt requests
    state_next.rise_irq = state_next.rise_en & state_next.rise_flag;
    state_next.fall_irq = state_next.fall_en & state_next.fall_flag;
    // reset request only from an enabled comparator
    state_next.reset_req = state_reg.rst_src & state_reg.enable & ~cmp_sync_val;
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.mode <= MODE_RESET;
      state_reg.mux <= MUX_RESET;
      state_reg.sync_oe_n <= 1'b1;
      state_reg.raw_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign cmp_enable = state_reg.enable;
  assign pos_hyst_sel = state_reg.pos_hyst;
  assign neg_hyst_sel = state_reg.neg_hyst;
  assign response_mode_sel = state_reg.mode;
  assign pos_input_sel = state_reg.mux[POS_SEL_LSB +: 4];
  assign neg_input_sel = state_reg.mux[NEG_SEL_LSB +: 4];
  assign sync_cmp_out = state_reg.sync_out;
  assign sync_cmp_oe_n = state_reg.sync_oe_n;
  assign raw_cmp_gate = state_reg.raw_gate;
  assign raw_cmp_oe_n = state_reg.raw_oe_n;
  assign rise_irq = state_reg.rise_irq;
  assign fall_irq = state_reg.fall_irq;
  assign cmp_reset_req = state_reg.reset_req;

  // ***************************************************************
  // assertions
  // ***************************************************************
  // edge events and sticky flags
  a_rise_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
    rise_evt |=> state_reg.rise_flag) else $error("rising flag not set");
  a_fall_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
    fall_evt |=> state_reg.fall_flag) else $error("falling flag not set");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.rise_flag && !wr_ctrl |=> state_reg.rise_flag)
    else $error("rising flag dropped");
  a_fall_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.fall_flag && !wr_ctrl |=> state_reg.fall_flag)
    else $error("falling flag dropped");
  a_set_beats_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl && rise_evt |=> state_reg.rise_flag)
    else $error("clear beat edge event");
  // masked requests follow enable and flag in the same cycle
  a_rise_irq_and: assert property (@(posedge clk) disable iff (!reset_n)
    rise_irq == (state_reg.rise_en && state_reg.rise_flag))
    else $error("rising irq mismatch");
  a_fall_irq_and: assert property (@(posedge clk) disable iff (!reset_n)
    fall_irq == (state_reg.fall_en && state_reg.fall_flag))
    else $error("falling irq mismatch");
  // pin drive and reset request
  a_disabled_low: assert property (@(posedge clk) disable iff (!reset_n)
    !state_reg.enable |=> !sync_cmp_out && !raw_cmp_gate)
    else $error("pin output not low when disabled");
  a_output_latch: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.enable && $stable(state_reg.enable) |=> sync_cmp_out == $past(cmp_sync_val))
    else $error("latched output wrong");
  a_push_pull_drive: assert property (@(posedge clk) disable iff (!reset_n)
    !state_reg.open_drain |=> !sync_cmp_oe_n && !raw_cmp_oe_n)
    else $error("push pull output not driven");
  a_open_drain_release: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.open_drain && state_reg.enable
    |=> raw_cmp_oe_n && (sync_cmp_oe_n == $past(cmp_sync_val)))
    else $error("open drain release wrong");
  a_reset_request: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.rst_src && state_reg.enable && !cmp_sync_val |=> cmp_reset_req)
    else $error("reset request missing");
  a_no_req_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    !state_reg.enable |=> !cmp_reset_req)
    else $error("reset request from disabled comparator");
  // bus answers one cycle after the request is complete
  a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (@(posedge clk) disable iff (!reset_n)
    wr_fire |=> s_axi_bvalid) else $error("write not answered");
  // main scenarios
  c_rise_irq: cover property (@(posedge clk) disable iff (!reset_n) rise_irq);
  c_fall_irq: cover property (@(posedge clk) disable iff (!reset_n) fall_irq);
  c_clear_race: cover property (@(posedge clk) disable iff (!reset_n) wr_ctrl && rise_evt);
  c_reset_req: cover property (@(posedge clk) disable iff (!reset_n) cmp_reset_req);
  c_open_drain: cover property (@(posedge clk) disable iff (!reset_n)
    raw_cmp_oe_n && !sync_cmp_oe_n);
endmodule

/* File: cmp_pkg.sv */
package cmp_pkg;
  // ***************************************************************
  // register byte addresses (printed offsets are not word aligned)
  // ***************************************************************
  localparam logic [7:0] CTRL_INDEX = 8'h9b; // control register index
  localparam logic [7:0] MODE_INDEX = 8'h9d; // mode register index
  localparam logic [7:0] MUX_INDEX = 8'h9f; // input select index
  localparam logic [7:0] PIN_INDEX = 8'ha0; // pin drive register index
  localparam logic [9:0] CTRL_ADDR = {CTRL_INDEX, 2'b00}; // byte address
  localparam logic [9:0] MODE_ADDR = {MODE_INDEX, 2'b00}; // byte address
  localparam logic [9:0] MUX_ADDR = {MUX_INDEX, 2'b00}; // byte address
  localparam logic [9:0] PIN_ADDR = {PIN_INDEX, 2'b00}; // byte address
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int EN_BIT = 7; // enable
  localparam int STATE_BIT = 6; // output state, read only
  localparam int RISE_BIT = 5; // rising flag / rising irq enable
  localparam int FALL_BIT = 4; // falling flag / falling irq enable
  localparam int POS_HYST_LSB = 2; // positive hysteresis field
  localparam int NEG_HYST_LSB = 0; // negative hysteresis field
  localparam int MODE_LSB = 0; // response mode field
  localparam int POS_SEL_LSB = 0; // positive input selector
  localparam int NEG_SEL_LSB = 4; // negative input selector
  localparam int SEL_NONE_BIT = 3; // selector msb means no pin
  localparam int OD_BIT = 0; // pin drive: 1 open drain
  localparam int RST_SRC_BIT = 1; // pin drive: reset source select
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00; // control reset
  localparam logic [1:0] MODE_RESET = 2'h2; // response mode 2
  localparam logic [7:0] MUX_RESET = 8'hff; // no input connected
  localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error
endpackage

/* File: cmp_sync.sv */
`timescale 1ns/1ns
// two flop synchroniser for the asynchronous comparator result
module cmp_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic meta; // first stage, read only by second stage
    logic sync; // second stage
  } sync_state_t;
  sync_state_t state_reg;
  sync_state_t state_next;

  // shift the sample along
  always_comb begin
    state_next = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
  end

  // registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.sync;

  // second stage follows first one cycle later
  a_sync_follow: assert property (@(posedge clk) disable iff (!reset_n)
    sync_out == $past(state_reg.meta)) else $error("sync stage did not follow");
endmodule

/* File: cmp_core_model.sv */
`timescale 1ns/1ns
// ***************************************************************
// behavioural analogue comparator core
// ***************************************************************
// the bench commands the input relation; no hysteresis or delay modelled
module cmp_core_model (
  input wire logic cmp_enable,
  input wire logic [3:0] pos_input_sel,
  input wire logic [3:0] neg_input_sel,
  input wire logic pos_above_neg,
  output logic cmp_result_async
);
  import cmp_pkg::*;
  // a powered down core or an unconnected input never reads high
  assign cmp_result_async = cmp_enable & ~pos_input_sel[SEL_NONE_BIT]
    & ~neg_input_sel[SEL_NONE_BIT] & pos_above_neg;
endmodule

/* File: comparator_control_logic_tb.sv */
`timescale 1ns/1ns
module comparator_control_logic_tb;
  import cmp_pkg::*;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic clk = 1'b0; // 20 mhz system clock
  logic reset_n; // async reset, active low
  logic [9:0] awaddr, araddr; // bus addresses
  logic awvalid, wvalid, bready, arvalid, rready; // bus handshakes
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [31:0] wdata, rdata; // bus data
  logic [3:0] wstrb; // byte lanes
  logic [1:0] bresp, rresp; // responses
  logic level; // commanded input relation
  logic result, cmp_enable, sync_cmp_out, sync_cmp_oe_n, raw_cmp_gate, raw_cmp_oe_n;
  logic rise_irq, fall_irq, cmp_reset_req;
  logic [1:0] pos_hyst_sel, neg_hyst_sel, response_mode_sel;
  logic [3:0] pos_input_sel, neg_input_sel;
  logic [31:0] rd_data; // last read word
  logic [1:0] resp; // last response
  int errors = 0; // mismatches seen
  int compares = 0; // comparisons made
  always #25 clk = ~clk;
  cmp_ctrl i_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_result_async(result), .cmp_enable(cmp_enable),
    .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
    .response_mode_sel(response_mode_sel), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .sync_cmp_out(sync_cmp_out),
    .sync_cmp_oe_n(sync_cmp_oe_n), .raw_cmp_gate(raw_cmp_gate),
    .raw_cmp_oe_n(raw_cmp_oe_n), .rise_irq(rise_irq), .fall_irq(fall_irq),
    .cmp_reset_req(cmp_reset_req));
  cmp_core_model i_core (.cmp_enable(cmp_enable), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .pos_above_neg(level), .cmp_result_async(result));
  // ***************************************************************
  // tasks
  // ***************************************************************
  // single place where the run ends
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // compare seen against expected, four state
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a hung handshake ends the run as a failure
  task automatic hang(input int n);
    if (n >= 100) begin
      errors++;
      $display("BAD %0t bus handshake never completed", $time);
      stop_test();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    resp = bresp;
    bready <= 1'b0;
    hang(n);
  endtask
  // read: rready held from the start until rvalid is seen
  task automatic rd(input logic [9:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rd_data = rdata;
    resp = rresp;
    rready <= 1'b0;
    hang(n);
  endtask
  // ***************************************************************
  // sequence
  // ***************************************************************
  initial begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, level} = '0;
    tick(2);
    reset_n <= 1'b1;
    // reset values of registers and ports
    rd(CTRL_ADDR);
    chk(rd_data, 32'h0);
    rd(MODE_ADDR);
    chk(rd_data, 32'h2);
    rd(MUX_ADDR);
    chk(rd_data, 32'hff);
    chk({30'h0, sync_cmp_oe_n, raw_cmp_oe_n}, 32'h0);
    $display("reset values done");
    // unmapped places refused, state bit not writable
    rd(10'h3fc);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(10'h000, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(CTRL_ADDR, 32'h40);
    rd(CTRL_ADDR);
    chk(rd_data, 32'h0);
    $display("refusals done");
    // selectors, every response mode, hysteresis and enable
    wr(MUX_ADDR, 32'h53);
    tick(2);
    chk({24'h0, neg_input_sel, pos_input_sel}, 32'h53);
    for (int m = 0; m < 4; m++) begin
      wr(MODE_ADDR, 32'h30 | 32'(m));
      tick(2);
      chk(32'(response_mode_sel), 32'(m));
      rd(MODE_ADDR);
      chk(rd_data, 32'h30 | 32'(m));
    end
    wr(CTRL_ADDR, 32'h89);
    tick(2);
    chk({28'h0, pos_hyst_sel, neg_hyst_sel}, 32'h9);
    chk(32'(cmp_enable), 32'h1);
    rd(CTRL_ADDR);
    chk(rd_data, 32'h89);
    $display("configuration done");
    // rising then falling transition; flags persist
    level <= 1'b1;
    tick(6);
    rd(CTRL_ADDR);
    chk(rd_data, 32'he9);
    chk({30'h0, rise_irq, fall_irq}, 32'h2);
    chk(32'(sync_cmp_out), 32'h1);
    chk(32'(raw_cmp_gate), 32'h1);
    level <= 1'b0;
    tick(6);
    rd(CTRL_ADDR);
    chk(rd_data, 32'hb9);
    chk({30'h0, rise_irq, fall_irq}, 32'h3);
    $display("edge flags done");
    // mask rising cause, then clear both flags by writing zero
    wr(MODE_ADDR, 32'h13);
    tick(2);
    chk({30'h0, rise_irq, fall_irq}, 32'h1);
    wr(CTRL_ADDR, 32'h89);
    tick(2);
    rd(CTRL_ADDR);
    chk(rd_data, 32'h89);
    chk(32'(fall_irq), 32'h0);
    $display("mask and clear done");
    // reset request while below threshold, then disable forces low
    wr(PIN_ADDR, 32'h2);
    tick(4);
    chk(32'(cmp_reset_req), 32'h1);
    level <= 1'b1;
    tick(6);
    chk(32'(cmp_reset_req), 32'h0);
    chk(32'(sync_cmp_out), 32'h1);
    wr(CTRL_ADDR, 32'h09);
    tick(6);
    chk({29'h0, cmp_enable, sync_cmp_out, raw_cmp_gate}, 32'h0);
    chk(32'(cmp_reset_req), 32'h0);
    $display("reset source and disable done");
    // open drain: released while high; synced output driven low while low, raw output stays released
    wr(PIN_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h89);
    tick(6);
    chk({30'h0, sync_cmp_oe_n, raw_cmp_oe_n}, 32'h3);
    level <= 1'b0;
    tick(6);
    chk({30'h0, sync_cmp_oe_n, raw_cmp_oe_n}, 32'h1);
    chk(32'(sync_cmp_out), 32'h0);
    rd(PIN_ADDR);
    chk(rd_data, 32'h1);
    $display("pin drive done");
    stop_test();
  end
endmodule
